// ### logic/hsr_cfg.svh
/*
  Shared constants of the strobe and hardware-reset block: widths,
  token layout and counter sizes.
  Assumes it is included by its bare name from the strobe block, the checker and the bench.
*/
`ifndef HSR_CFG_SVH
`define HSR_CFG_SVH

// ==========================================================
// bus and bit counter widths
`define HSR_DAT_W 8
`define HSR_CNT_W 3

// ==========================================================
// crc status token: start bit, three status bits, end bit
`define HSR_CRC_LEN 3'h5
`define HSR_CRC_START 1'h0
`define HSR_CRC_END 1'h1
`define HSR_CRC_MSB 4

// ==========================================================
// idle levels of the outputs
`define HSR_STROBE_IDLE 1'h0
`define HSR_LINE_IDLE 1'h1

// ==========================================================
// idle levels of the sampled pins, loaded into their synchronisers
`define HSR_CLK_PIN_IDLE 1'h0
`define HSR_RST_PIN_IDLE 1'h1

`endif

// ### logic/hsr_pkg.sv
/*
  Types of the strobe and hardware-reset block.
  Assumes hsr_cfg.svh is on the include path.
*/
`default_nettype none

package hsr_pkg;

  // ==========================================================
  // transmit sequencer states
  typedef enum logic [2:0] {
    HSR_IDLE  = 3'h0,
    HSR_READ  = 3'h1,
    HSR_CRC   = 3'h2,
    HSR_RSP   = 3'h3,
    HSR_DRAIN = 3'h4
  } hsr_state_t;

endpackage

`default_nettype wire

// ### logic/hsr_sync_edge.sv
/*
  Two-flop synchroniser with registered edge detection for one
  asynchronous pin (host clock or reset pin).
  Assumes the input has no relation to mclk and is slower than mclk / 2.
*/
`default_nettype none

module hsr_sync_edge #(
  parameter logic RESET_LEVEL = 1'h0
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic asyncIn,
  output logic levelOut,
  output logic riseOut,
  output logic fallOut
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;
  logic rise_reg;
  logic fall_reg;

  // ==========================================================
  // synchroniser: meta_reg feeds sync_reg only
  // reset to the pin's idle level, else release of sys_rst looks like an edge
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_reg <= RESET_LEVEL;
      sync_reg <= RESET_LEVEL;
    end
    else
    begin
      meta_reg <= asyncIn;
      sync_reg <= meta_reg;
    end
  end

  // ==========================================================
  // edge detection on the settled copy only
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prev_reg <= RESET_LEVEL;
      rise_reg <= 1'h0;
      fall_reg <= 1'h0;
    end
    else
    begin
      prev_reg <= sync_reg;
      rise_reg <= sync_reg & ~prev_reg;
      fall_reg <= ~sync_reg & prev_reg;
    end
  end

  assign levelOut = prev_reg;
  assign riseOut = rise_reg;
  assign fallOut = fall_reg;

endmodule

`default_nettype wire

// ### logic/hsr_strobe_reset.sv
/*
  Device end of the host bus in HS400: data strobe generation for read
  data, crc status tokens and command responses, plus the hardware
  reset pin detector.
  Assumes the host clock and reset pin are asynchronous to mclk and that
  mclk runs well above twice the sampled host clock rate.
*/
// What this block does and expects of the host
// R1: HS400 read data goes out with strobe
// R2: strobe idle except read data, crc status
// R3: HS400 command response also toggles strobe
// R4: host clock period at least 5 ns
// R5: reset sequence starts on reset pin rise
// R6: host reset pulse and gap 1 us
// R7: host waits 200 us before commands
// R8: host gives 74 clocks before CMD1
// R9: reset pin ignored until setting loaded
// R10: HS400 read data launched on both edges
// R11: reset pin ignored when function disabled
`include "hsr_cfg.svh"
`default_nettype none

module hsr_strobe_reset
  import hsr_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic hostClk,
  input wire logic hwRstN,
  input wire logic hs400Mode,
  input wire logic rstFuncEn,
  input wire logic cfgLoaded,
  input wire logic rdValid,
  input wire logic [`HSR_DAT_W-1:0] rdByte,
  input wire logic rdLast,
  output logic rdReady,
  input wire logic crcReq,
  input wire logic [2:0] crcStatus,
  input wire logic rspValid,
  input wire logic rspBit,
  input wire logic rspLast,
  output logic rspReady,
  output logic [`HSR_DAT_W-1:0] datOut,
  output logic datOe,
  output logic cmdOut,
  output logic cmdOe,
  output logic dataStrobe,
  output logic resetSeqStart,
  output logic busy
);

  hsr_state_t state_reg;
  logic strobe_reg;
  logic [`HSR_DAT_W-1:0] dat_reg;
  logic datOe_reg;
  logic cmd_reg;
  logic cmdOe_reg;
  logic crcPend_reg;
  logic [2:0] crcStat_reg;
  logic [`HSR_CRC_MSB:0] crcShift_reg;
  logic [`HSR_CNT_W-1:0] bitCnt_reg;
  logic rstStart_reg;
  logic hostRise;
  logic hostFall;
  logic pinRise;
  logic readEdge;
  logic drainEdge;
  logic crcTake;

  // ==========================================================
  // pin synchronisers: host clock and reset pin
  hsr_sync_edge #(
    .RESET_LEVEL(`HSR_CLK_PIN_IDLE)
  ) uClkSync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .asyncIn(hostClk),
    .levelOut(),
    .riseOut(hostRise),
    .fallOut(hostFall)
  );

  // pin idles high: a low reset level would fake a release after sys_rst
  hsr_sync_edge #(
    .RESET_LEVEL(`HSR_RST_PIN_IDLE)
  ) uRstSync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .asyncIn(hwRstN),
    .levelOut(),
    .riseOut(pinRise),
    .fallOut()
  );

  // ==========================================================
  // edge qualifiers: double rate only in HS400
  assign readEdge = hostRise | (hs400Mode & hostFall); // R10
  assign drainEdge = hs400Mode ? (hostRise | hostFall) : hostRise;
  assign crcTake = (state_reg == HSR_IDLE) & ~rspValid & crcPend_reg;

  // handshakes consume one item per launching edge
  assign rdReady = (state_reg == HSR_READ) & readEdge & rdValid & ~rstStart_reg;
  assign rspReady = (state_reg == HSR_RSP) & hostRise & rspValid & ~rstStart_reg;

  // ==========================================================
  // reset pin: only the release edge counts, and only once enabled
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rstStart_reg <= 1'h0;
    end
    else
    begin
      rstStart_reg <= pinRise & rstFuncEn & cfgLoaded; // R5 R9 R11
    end
  end

  // ==========================================================
  // pending crc status request; a new request beats the take
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      crcPend_reg <= 1'h0;
      crcStat_reg <= 3'h0;
    end
    else if (crcReq)
    begin
      crcPend_reg <= 1'h1;
      crcStat_reg <= crcStatus;
    end
    else if (crcTake | rstStart_reg)
    begin
      crcPend_reg <= 1'h0;
    end
  end

  // ==========================================================
  // sequencer: responses first since the host is waiting on cmd
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= HSR_IDLE;
      bitCnt_reg <= '0;
    end
    else if (rstStart_reg)
    begin
      state_reg <= HSR_IDLE;
      bitCnt_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        HSR_IDLE:
        begin
          bitCnt_reg <= '0;
          if (rspValid)
            state_reg <= HSR_RSP;
          else if (crcPend_reg)
            state_reg <= HSR_CRC;
          else if (rdValid)
            state_reg <= HSR_READ;
        end
        HSR_READ:
        begin
          if (rdReady & rdLast)
            state_reg <= HSR_DRAIN;
        end
        HSR_CRC:
        begin
          if (hostRise)
          begin
            bitCnt_reg <= bitCnt_reg + `HSR_CNT_W'(1);
            if (bitCnt_reg == `HSR_CRC_LEN - 3'h1)
              state_reg <= HSR_DRAIN;
          end
        end
        HSR_RSP:
        begin
          if (rspReady & rspLast)
            state_reg <= HSR_DRAIN;
        end
        HSR_DRAIN:
        begin
          // hold the last item until drainEdge: a full unit interval, but only half for crc and response bits in HS400
          if (drainEdge)
            state_reg <= HSR_IDLE;
        end
        default:
        begin
          state_reg <= HSR_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // data lines: read bytes and the crc token on line 0
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dat_reg <= {`HSR_DAT_W{`HSR_LINE_IDLE}};
      datOe_reg <= 1'h0;
      crcShift_reg <= '1;
    end
    else if (rstStart_reg)
    begin
      dat_reg <= {`HSR_DAT_W{`HSR_LINE_IDLE}};
      datOe_reg <= 1'h0;
    end
    else
    begin
      if (crcTake)
        crcShift_reg <= {`HSR_CRC_START, crcStat_reg, `HSR_CRC_END};
      if (rdReady)
      begin
        dat_reg <= rdByte; // R1 R10
        datOe_reg <= 1'h1;
      end
      else if ((state_reg == HSR_CRC) & hostRise)
      begin
        dat_reg <= {{(`HSR_DAT_W-1){`HSR_LINE_IDLE}}, crcShift_reg[`HSR_CRC_MSB]};
        crcShift_reg <= {crcShift_reg[`HSR_CRC_MSB-1:0], `HSR_LINE_IDLE};
        datOe_reg <= 1'h1;
      end
      else if ((state_reg == HSR_DRAIN) & drainEdge)
      begin
        dat_reg <= {`HSR_DAT_W{`HSR_LINE_IDLE}};
        datOe_reg <= 1'h0;
      end
    end
  end

  // ==========================================================
  // command line: response bits launched on host rising edges
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cmd_reg <= `HSR_LINE_IDLE;
      cmdOe_reg <= 1'h0;
    end
    else if (rstStart_reg)
    begin
      cmd_reg <= `HSR_LINE_IDLE;
      cmdOe_reg <= 1'h0;
    end
    else if (rspReady)
    begin
      cmd_reg <= rspBit;
      cmdOe_reg <= 1'h1;
    end
    else if ((state_reg == HSR_DRAIN) & drainEdge & cmdOe_reg)
    begin
      cmd_reg <= `HSR_LINE_IDLE;
      cmdOe_reg <= 1'h0;
    end
  end

  // ==========================================================
  // data strobe: toggles only while something is sent, HS400 only,
  // and always ends low so the host sees a clean idle level
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strobe_reg <= `HSR_STROBE_IDLE;
    end
    else if (rstStart_reg | ~hs400Mode)
    begin
      strobe_reg <= `HSR_STROBE_IDLE; // R2
    end
    else if (rdReady)
    begin
      strobe_reg <= ~strobe_reg; // R1 R10
    end
    else if ((state_reg == HSR_CRC) | (state_reg == HSR_RSP))
    begin
      // follows the host clock so bits are centred on a full strobe cycle
      if (hostRise)
        strobe_reg <= 1'h1; // R3
      else if (hostFall)
        strobe_reg <= 1'h0; // R3
    end
    else if ((state_reg == HSR_DRAIN) & drainEdge)
    begin
      strobe_reg <= `HSR_STROBE_IDLE; // R2
    end
  end

  assign datOut = dat_reg;
  assign datOe = datOe_reg;
  assign cmdOut = cmd_reg;
  assign cmdOe = cmdOe_reg;
  assign dataStrobe = strobe_reg;
  assign resetSeqStart = rstStart_reg;
  assign busy = (state_reg != HSR_IDLE);

endmodule

`default_nettype wire

// ### tb/hsr_strobe_reset_props.sv
/*
  Checker of the strobe and reset block.
  Assumes it is bound to hsr_strobe_reset.
*/
`include "hsr_cfg.svh"
`default_nettype none

module hsr_strobe_reset_props (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic hwRstN,
  input wire logic hs400Mode,
  input wire logic rstFuncEn,
  input wire logic cfgLoaded,
  input wire logic rdReady,
  input wire logic [`HSR_DAT_W-1:0] rdByte,
  input wire logic rspReady,
  input wire logic rspBit,
  input wire logic [`HSR_DAT_W-1:0] datOut,
  input wire logic datOe,
  input wire logic cmdOut,
  input wire logic cmdOe,
  input wire logic dataStrobe,
  input wire logic resetSeqStart,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // an enabled pin release, then the abort it causes
  sequence pinRise;
    $rose(hwRstN) && rstFuncEn && cfgLoaded;
  endsequence
  sequence allIdle;
    !datOe && !cmdOe && !busy;
  endsequence
  AST_SDR_STROBE: assert property (!hs400Mode [*3] |-> !dataStrobe)
    else $error("strobe outside hs400");
  AST_STROBE_IDLE: assert property (!datOe && !cmdOe |-> !dataStrobe)
    else $error("strobe while idle");
  AST_READ_LAUNCH: assert property (rdReady |=> datOe && datOut == $past(rdByte))
    else $error("read byte not launched");
  AST_READ_TOGGLE: assert property (rdReady && hs400Mode |=> dataStrobe != $past(dataStrobe))
    else $error("no strobe edge with byte");
  AST_RSP_STROBE: assert property (rspReady && hs400Mode |=> cmdOe && dataStrobe && cmdOut == $past(rspBit))
    else $error("response bit without strobe");
  AST_PIN_RISE: assert property (pinRise |-> ##[3:5] resetSeqStart)
    else $error("reset sequence missed");
  AST_ABORT: assert property (resetSeqStart |=> allIdle)
    else $error("outputs not idle after reset");
  AST_NOT_LOADED: assert property (!cfgLoaded [*8] |-> !resetSeqStart)
    else $error("reset before setting loaded");
  AST_DISABLED: assert property (!rstFuncEn [*8] |-> !resetSeqStart)
    else $error("reset while disabled");
endmodule

bind hsr_strobe_reset hsr_strobe_reset_props props (.mclk(mclk), .sys_rst(sys_rst),
  .hwRstN(hwRstN), .hs400Mode(hs400Mode), .rstFuncEn(rstFuncEn), .cfgLoaded(cfgLoaded),
  .rdReady(rdReady), .rdByte(rdByte), .rspReady(rspReady), .rspBit(rspBit),
  .datOut(datOut), .datOe(datOe), .cmdOut(cmdOut), .cmdOe(cmdOe),
  .dataStrobe(dataStrobe), .resetSeqStart(resetSeqStart), .busy(busy));

`default_nettype wire

// ### tb/hsr_host_model.sv
/*
  Host side: bus clock in frames and the reset pin.
  Assumes mclk at 25 MHz; inputs change on its falling edge.
*/
`default_nettype none

module hsr_host_model (
  input wire logic mclk,
  output logic hostClk,
  output logic hwRstN
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // clock stands low between frames, pin idles high
  initial
  begin
    hostClk = 1'b0;
    hwRstN = 1'b1;
  end
  // 320 ns period, far slower than the 5 ns floor
  task automatic runClocks(input int n);
    repeat (2 * n)
    begin
      repeat (4) @(negedge mclk);
      hostClk = ~hostClk;
    end
  endtask
  // pulse and gap above 1 us, then the wait before any command
  task automatic pulseReset();
    @(negedge mclk);
    hwRstN = 1'b0;
    repeat (26) @(negedge mclk);
    hwRstN = 1'b1;
    repeat (5000) @(negedge mclk);
    runClocks(74);
  endtask
endmodule

`default_nettype wire

// ### tb/test_hsr_strobe_reset.sv
/*
  Bench of the strobe and reset block: drivers, monitor, verdict.
  Assumes design files, checker and host model compile first.
*/
`include "hsr_cfg.svh"
`default_nettype none

module test_hsr_strobe_reset;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic sys_rst, hostClk, hwRstN, hs400Mode, rstFuncEn, cfgLoaded, rdValid, rdLast, rdReady;
  logic crcReq, rspValid, rspBit, rspLast, rspReady, datOe, cmdOut, cmdOe, dataStrobe;
  logic resetSeqStart, busy;
  logic prevStrobe = 1'b0;
  logic prevHost = 1'b0;
  logic [`HSR_DAT_W-1:0] rdByte, datOut;
  logic [2:0] crcStatus;
  logic [8:0] expQ[$];
  int numErrors = 0;
  int samplesChecked = 0;
  int rstCount = 0;

  // ==========================================================
  // clock and instances
  always #20 mclk = ~mclk;
  hsr_host_model host (.mclk(mclk), .hostClk(hostClk), .hwRstN(hwRstN));
  hsr_strobe_reset dut (.mclk(mclk), .sys_rst(sys_rst), .hostClk(hostClk), .hwRstN(hwRstN),
    .hs400Mode(hs400Mode), .rstFuncEn(rstFuncEn), .cfgLoaded(cfgLoaded), .rdValid(rdValid),
    .rdByte(rdByte), .rdLast(rdLast), .rdReady(rdReady), .crcReq(crcReq),
    .crcStatus(crcStatus), .rspValid(rspValid), .rspBit(rspBit), .rspLast(rspLast),
    .rspReady(rspReady), .datOut(datOut), .datOe(datOe), .cmdOut(cmdOut), .cmdOe(cmdOe),
    .dataStrobe(dataStrobe), .resetSeqStart(resetSeqStart), .busy(busy));

  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    samplesChecked++;
    if (seen !== want)
    begin
      numErrors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic printVerdict();
    if (numErrors == 0 && samplesChecked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // offer n units, each held until the design takes it
  task automatic sendStream(input logic useRsp, input int n);
    logic [7:0] b;
    int k;
    for (int i = 0; i < n; i++)
    begin
      b = 8'($urandom);
      rspBit = b[0];
      rspLast = (i == n - 1);
      rspValid = useRsp;
      rdByte = b;
      rdLast = (i == n - 1);
      rdValid = !useRsp;
      // a read byte in either mode; a response bit once per strobe edge
      if (!useRsp)
        expQ.push_back({1'b1, b});
      else if (hs400Mode)
        repeat ((i < n - 1) ? 2 : 1) expQ.push_back({8'h80, b[0]});
      k = 0;
      do
      begin
        @(posedge mclk);
        k++;
      end
      while ((useRsp ? rspReady : rdReady) !== 1'b1 && k < 400);
      if (k >= 400)
      begin
        numErrors++;
        printVerdict();
      end
      else
        @(negedge mclk);
    end
    // released lines no longer show the last unit
    rdValid = 1'b0;
    rspValid = 1'b0;
    rdByte = ~rdByte;
    rspBit = ~rspBit;
  endtask

  // the host latches data lines on every strobe edge while datOe is high
  always @(posedge mclk)
  begin
    prevStrobe <= dataStrobe;
    prevHost <= hostClk;
    if (resetSeqStart === 1'b1)
      rstCount++;
    if (dataStrobe !== prevStrobe && datOe === 1'b1)
      check({datOe, datOut}, expQ.size() ? expQ.pop_front() : 9'h000);
    // response bits are latched on the strobe as well
    if (dataStrobe !== prevStrobe && cmdOe === 1'b1)
      check({cmdOe, 7'h00, cmdOut}, expQ.size() ? expQ.pop_front() : 9'h000);
    // without strobe the host latches on its own rising clock edge
    if (hs400Mode === 1'b0 && hostClk === 1'b1 && prevHost === 1'b0 && datOe === 1'b1)
      check({datOe, datOut}, expQ.size() ? expQ.pop_front() : 9'h000);
  end

  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    hs400Mode = 1'b1;
    rstFuncEn = 1'b1;
    cfgLoaded = 1'b0;
    rdValid = 1'b0;
    rdByte = 8'h00;
    rdLast = 1'b0;
    crcReq = 1'b0;
    crcStatus = 3'h0;
    rspValid = 1'b0;
    rspBit = 1'b0;
    rspLast = 1'b0;
    void'($urandom(26));
    repeat (8) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (8) @(negedge mclk);
    // not loaded, disabled, then enabled: only the last starts a sequence
    for (int c = 0; c < 3; c++)
    begin
      cfgLoaded = (c != 0);
      rstFuncEn = (c != 1);
      repeat (10) @(negedge mclk);
      host.pulseReset();
    end
    check(9'(rstCount), 9'h001);
    for (int m = 0; m < 2; m++)
    begin
      hs400Mode = (m == 0);
      fork
        host.runClocks(8);
        sendStream(1'b0, 4);
      join
    end
    hs400Mode = 1'b1;
    // every crc status code; the last bit's strobe fall lands in drain
    for (int s = 0; s < 8; s++)
    begin
      crcStatus = 3'(s);
      crcReq = 1'b1;
      for (int i = 4; i >= 0; i--)
        repeat (i > 0 ? 2 : 1) expQ.push_back({8'hFF, {1'b0, crcStatus, 1'b1}[i]});
      @(negedge mclk);
      crcReq = 1'b0;
      host.runClocks(6);
    end
    fork
      host.runClocks(12);
      sendStream(1'b1, 8);
    join
    repeat (20) @(negedge mclk);
    check(9'(expQ.size()), 9'h000);
    printVerdict();
  end
endmodule

`default_nettype wire
